// [logic/pcb_cfg_bridge.sv]
// Bridge configuration decoder: own Type 0 target and Type 1 to Type 0 master
//
// Notes on behaviour
// - Config command with address bits 1:0 = 00b is Type 0.
// - Config command with address bits 1:0 = 01b is Type 1.
// - Claim own space only for config command, 00b and primary IDSEL.
// - Function number ignored; single-function device.
// - Type 0 cycles on the secondary bus are never claimed.
// - Own accesses are one Dword; disconnect with first data if more asked.
// - Own reads return all four bytes regardless of byte enables.
// - Own reads and writes complete at once, no retry, no buffers.
// - Type 0 cycles are generated only on the secondary bus.
// - Type 1 claimed when 01b and bus field 23:16 equals secondary bus.
// - Translated address: bits 1:0 and 15:11 zero, function/register kept.
// - Devices 0-15 get one-hot IDSEL on secondary bits 31:16.
// - Devices 10h-1Eh: upper bits all low, still forwarded.
// - Device 1Fh with register 00h on a write is a special cycle, else upper bits zero.
// - No DEVSEL on the translated cycle ends it with master abort.
// - Translated accesses are delayed, never completed on first attempt.
// - Each translated access carries exactly one 32-bit data phase.
// - Device number is a 5-bit field; register number is a Dword index.
// - First attempt ends in retry; initiator repeats until completion.
`timescale 1ns/1ps
`include "pcb_cfg.svh"

module pcb_cfg_bridge
  import pcb_pkg::*;
#(
  parameter int CFG_DWORDS = 64
) (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        NRST,
  // Primary bus, target side
  input  wire logic        P_FRAME_N,
  input  wire logic        P_IRDY_N,
  input  wire logic        P_IDSEL,
  input  wire logic [31:0] P_AD_IN,
  input  wire logic [3:0]  P_CBE_N,
  output logic [31:0]      P_AD_OUT,
  output logic             P_AD_OE,
  output logic             P_DEVSEL_N,
  output logic             P_TRDY_N,
  output logic             P_STOP_N,
  output logic             P_CTL_OE,
  // Secondary bus, master side
  input  wire logic        S_GNT_N,
  input  wire logic [31:0] S_AD_IN,
  input  wire logic        S_DEVSEL_N,
  input  wire logic        S_TRDY_N,
  input  wire logic        S_STOP_N,
  output logic             S_REQ_N,
  output logic             S_FRAME_N,
  output logic             S_IRDY_N,
  output logic             S_CTL_OE,
  output logic [31:0]      S_AD_OUT,
  output logic             S_AD_OE,
  output logic [3:0]       S_CBE_N,
  output logic             S_CBE_OE
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  pcb_pstate_t pstate, next_pstate;
  pcb_sstate_t sstate, next_sstate;
  pcb_dec_t    dec;
  pcb_xl_t     xl;
  pcb_req_t    dly, next_dly;
  logic [31:0] cfg_mem [CFG_DWORDS];
  logic [31:0] next_word, next_p_ad, next_s_ad, dly_rdata, next_dly_rdata;
  logic [7:0]  sec_bus;
  logic [5:0]  cur_idx, next_cur_idx;
  logic [3:0]  next_s_cbe_n;
  logic [2:0]  s_cnt, next_s_cnt;
  logic        frame_q, addr_phase, xfer, dly_hit;
  logic        cur_wr, next_cur_wr, cur_dly, next_cur_dly, cur_own, next_cur_own;
  logic        next_p_ad_oe, next_p_devsel_n, next_p_trdy_n, next_p_stop_n;
  logic        next_p_ctl_oe;
  logic        dly_alloc, dly_arm, dly_retire, cfg_we;
  logic        dly_valid, next_dly_valid, dly_armed, next_dly_armed;
  logic        dly_done, next_dly_done, dly_abort, next_dly_abort;
  logic        next_s_req_n, next_s_frame_n, next_s_irdy_n, next_s_ctl_oe;
  logic        next_s_ad_oe, next_s_cbe_oe, s_fin;

  assign sec_bus    = cfg_mem[`PCB_SECBUS_DW][`PCB_SECBUS_LSB +: 8];
  assign addr_phase = (pstate == PT_IDLE) && !P_FRAME_N && frame_q;
  assign xfer       = !P_IRDY_N && !P_TRDY_N;
  assign dly_hit    = dly_valid && (P_AD_IN == dly.addr) && (P_CBE_N == dly.cmd);

  // Decoder sees primary pins only, so nothing on the secondary side is claimed
  pcb_cfg_decode u_decode (
    .ad      (P_AD_IN),
    .cbe_n   (P_CBE_N),
    .idsel   (P_IDSEL),
    .sec_bus (sec_bus),
    .dec     (dec)
  );

  pcb_idsel_xlate u_xlate (
    .t1_addr  (dly.addr),
    .is_write (dly.cmd == `PCB_CMD_CFG_WR),
    .xl       (xl)
  );

  // --------------------------------------------------------------------
  // Primary target
  // --------------------------------------------------------------------
  always_comb begin
    next_pstate     = pstate;
    next_p_devsel_n = 1'b1;
    next_p_trdy_n   = 1'b1;
    next_p_stop_n   = 1'b1;
    next_p_ctl_oe   = 1'b0;
    next_p_ad       = P_AD_OUT;
    next_p_ad_oe    = 1'b0;
    next_cur_idx    = cur_idx;
    next_cur_wr     = cur_wr;
    next_cur_dly    = cur_dly;
    next_cur_own    = cur_own;
    dly_alloc       = 1'b0;
    dly_arm         = 1'b0;
    dly_retire      = 1'b0;
    cfg_we          = 1'b0;
    case (pstate)
      PT_IDLE: begin
        if (addr_phase && dec.claim0) begin
          next_pstate     = PT_DATA;
          next_p_devsel_n = 1'b0;
          next_p_ctl_oe   = 1'b1;
          next_cur_idx    = dec.reg_idx;
          next_cur_wr     = dec.is_write;
          next_cur_dly    = 1'b0;
          next_p_ad       = cfg_mem[dec.reg_idx];
        end else if (addr_phase && dec.claim1) begin
          next_p_devsel_n = 1'b0;
          next_p_ctl_oe   = 1'b1;
          next_cur_wr     = dec.is_write;
          next_cur_own    = 1'b0;
          if (dly_hit && dly_done && dly_abort) begin
            next_pstate = PT_TABORT;
          end else if (dly_hit && dly_done) begin
            next_pstate  = PT_DATA;
            next_cur_dly = 1'b1;
            next_p_ad    = dly_rdata;
          end else begin
            // Single entry: any other request is retried until it drains
            next_pstate   = PT_RETRY;
            next_p_stop_n = 1'b0;
            if (!dly_valid) begin
              dly_alloc    = 1'b1;
              next_cur_own = 1'b1;
            end
          end
        end
      end
      PT_DATA: begin
        next_p_devsel_n = 1'b0;
        next_p_ctl_oe   = 1'b1;
        next_p_trdy_n   = 1'b0;
        next_p_stop_n   = P_STOP_N;
        next_p_ad_oe    = !cur_wr;
        if (P_TRDY_N) begin
          next_p_stop_n = P_FRAME_N;
        end else if (xfer) begin
          cfg_we        = cur_wr && !cur_dly;
          dly_retire    = cur_dly;
          next_p_trdy_n = 1'b1;
          next_p_ad_oe  = 1'b0;
          if (!P_FRAME_N) begin
            next_pstate   = PT_HOLD;
            next_p_stop_n = 1'b0;
          end else begin
            next_pstate     = PT_TURN;
            next_p_devsel_n = 1'b1;
            next_p_stop_n   = 1'b1;
          end
        end
      end
      PT_HOLD, PT_RETRY: begin
        next_p_devsel_n = 1'b0;
        next_p_stop_n   = 1'b0;
        next_p_ctl_oe   = 1'b1;
        if (P_FRAME_N) begin
          next_pstate     = PT_TURN;
          next_p_devsel_n = 1'b1;
          next_p_stop_n   = 1'b1;
          // Byte enables are valid only once IRDY is low
          if (pstate == PT_RETRY && cur_own && !P_IRDY_N) begin
            dly_arm = 1'b1;
          end else if (pstate == PT_RETRY && cur_own) begin
            dly_retire = 1'b1;
          end
        end else if (pstate == PT_RETRY && cur_own && !P_IRDY_N && !dly_armed) begin
          dly_arm = 1'b1;
        end
      end
      PT_TABORT: begin
        next_p_stop_n = 1'b0;
        next_p_ctl_oe = 1'b1;
        // STOP must stand one edge even if FRAME is already high
        if (P_FRAME_N && !P_STOP_N) begin
          next_pstate   = PT_TURN;
          next_p_stop_n = 1'b1;
          dly_retire    = 1'b1;
        end
      end
      PT_TURN: begin
        next_pstate = PT_IDLE;
      end
      default: begin
        next_pstate = PT_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      pstate     <= PT_IDLE;
      frame_q    <= 1'b1;
      P_DEVSEL_N <= 1'b1;
      P_TRDY_N   <= 1'b1;
      P_STOP_N   <= 1'b1;
      P_CTL_OE   <= 1'b0;
      P_AD_OUT   <= `PCB_CFG_RST;
      P_AD_OE    <= 1'b0;
      cur_idx    <= 6'h00;
      cur_wr     <= 1'b0;
      cur_dly    <= 1'b0;
      cur_own    <= 1'b0;
    end else begin
      pstate     <= next_pstate;
      frame_q    <= P_FRAME_N;
      P_DEVSEL_N <= next_p_devsel_n;
      P_TRDY_N   <= next_p_trdy_n;
      P_STOP_N   <= next_p_stop_n;
      P_CTL_OE   <= next_p_ctl_oe;
      P_AD_OUT   <= next_p_ad;
      P_AD_OE    <= next_p_ad_oe;
      cur_idx    <= next_cur_idx;
      cur_wr     <= next_cur_wr;
      cur_dly    <= next_cur_dly;
      cur_own    <= next_cur_own;
    end
  end

  // --------------------------------------------------------------------
  // Own configuration space
  // --------------------------------------------------------------------
  always_comb begin
    next_word = cfg_mem[cur_idx];
    for (int b = 0; b < 4; b++) begin
      if (!P_CBE_N[b]) begin
        next_word[8*b +: 8] = P_AD_IN[8*b +: 8];
      end
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < CFG_DWORDS; i++) begin
        cfg_mem[i] <= `PCB_CFG_RST;
      end
    end else if (cfg_we) begin
      cfg_mem[cur_idx] <= next_word;
    end
  end

  // --------------------------------------------------------------------
  // Delayed entry and secondary master
  // --------------------------------------------------------------------
  always_comb begin
    next_dly       = dly;
    next_dly_valid = dly_valid;
    next_dly_armed = dly_armed;
    next_dly_done  = dly_done;
    next_dly_abort = dly_abort;
    next_dly_rdata = dly_rdata;
    next_sstate    = sstate;
    next_s_req_n   = 1'b1;
    next_s_frame_n = 1'b1;
    next_s_irdy_n  = 1'b1;
    next_s_ctl_oe  = 1'b0;
    next_s_ad      = S_AD_OUT;
    next_s_ad_oe   = 1'b0;
    next_s_cbe_n   = S_CBE_N;
    next_s_cbe_oe  = 1'b0;
    next_s_cnt     = s_cnt;
    s_fin          = 1'b0;
    if (dly_alloc) begin
      next_dly_valid = 1'b1;
      next_dly.addr  = P_AD_IN;
      next_dly.cmd   = P_CBE_N;
      next_dly_armed = 1'b0;
      next_dly_done  = 1'b0;
      next_dly_abort = 1'b0;
    end
    if (dly_arm) begin
      next_dly_armed = 1'b1;
      next_dly.be_n  = P_CBE_N;
      next_dly.wdata = P_AD_IN;
    end
    if (dly_retire) begin
      next_dly_valid = 1'b0;
      next_dly_armed = 1'b0;
      next_dly_done  = 1'b0;
    end
    case (sstate)
      ST_IDLE: begin
        if (dly_valid && dly_armed && !dly_done) begin
          next_s_req_n = 1'b0;
          next_sstate  = ST_REQ;
        end
      end
      ST_REQ: begin
        next_s_req_n = 1'b0;
        if (!dly_valid) begin
          next_s_req_n = 1'b1;
          next_sstate  = ST_IDLE;
        end else if (!S_GNT_N) begin
          next_s_req_n   = 1'b1;
          next_s_frame_n = 1'b0;
          next_s_ctl_oe  = 1'b1;
          next_s_ad      = xl.special ? dly.addr : xl.addr;
          next_s_ad_oe   = 1'b1;
          next_s_cbe_n   = xl.special ? `PCB_CMD_SPECIAL : dly.cmd;
          next_s_cbe_oe  = 1'b1;
          next_sstate    = ST_ADDR;
        end
      end
      ST_ADDR: begin
        next_s_irdy_n = 1'b0;
        next_s_ctl_oe = 1'b1;
        next_s_cbe_n  = dly.be_n;
        next_s_cbe_oe = 1'b1;
        next_s_ad     = dly.wdata;
        next_s_ad_oe  = (dly.cmd != `PCB_CMD_CFG_RD);
        next_s_cnt    = 3'h0;
        next_sstate   = ST_DATA;
      end
      ST_DATA: begin
        next_s_irdy_n = 1'b0;
        next_s_ctl_oe = 1'b1;
        next_s_cbe_oe = 1'b1;
        next_s_ad_oe  = S_AD_OE;
        next_s_cnt    = s_cnt + 3'h1;
        if (!S_DEVSEL_N && !S_TRDY_N) begin
          s_fin          = 1'b1;
          next_dly_done  = 1'b1;
          next_dly_rdata = S_AD_IN;
        end else if (!S_STOP_N && !S_DEVSEL_N) begin
          s_fin = 1'b1;
        end else if (!S_STOP_N) begin
          s_fin          = 1'b1;
          next_dly_done  = 1'b1;
          next_dly_abort = 1'b1;
        end else if (S_DEVSEL_N && s_cnt == `PCB_MABORT_CYC - 3'h1) begin
          // Nobody selected: reads see all ones, writes are dropped
          s_fin          = 1'b1;
          next_dly_done  = 1'b1;
          next_dly_rdata = `PCB_ALL_ONES;
        end
        if (s_fin) begin
          next_s_irdy_n = 1'b1;
          next_s_ad_oe  = 1'b0;
          next_s_cbe_oe = 1'b0;
          next_sstate   = ST_TURN;
        end
      end
      ST_TURN: begin
        next_sstate = ST_IDLE;
      end
      default: begin
        next_sstate = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      dly       <= '0;
      dly_valid <= 1'b0;
      dly_armed <= 1'b0;
      dly_done  <= 1'b0;
      dly_abort <= 1'b0;
      dly_rdata <= `PCB_CFG_RST;
      sstate    <= ST_IDLE;
      S_REQ_N   <= 1'b1;
      S_FRAME_N <= 1'b1;
      S_IRDY_N  <= 1'b1;
      S_CTL_OE  <= 1'b0;
      S_AD_OUT  <= `PCB_CFG_RST;
      S_AD_OE   <= 1'b0;
      S_CBE_N   <= 4'hF;
      S_CBE_OE  <= 1'b0;
      s_cnt     <= 3'h0;
    end else begin
      dly       <= next_dly;
      dly_valid <= next_dly_valid;
      dly_armed <= next_dly_armed;
      dly_done  <= next_dly_done;
      dly_abort <= next_dly_abort;
      dly_rdata <= next_dly_rdata;
      sstate    <= next_sstate;
      S_REQ_N   <= next_s_req_n;
      S_FRAME_N <= next_s_frame_n;
      S_IRDY_N  <= next_s_irdy_n;
      S_CTL_OE  <= next_s_ctl_oe;
      S_AD_OUT  <= next_s_ad;
      S_AD_OE   <= next_s_ad_oe;
      S_CBE_N   <= next_s_cbe_n;
      S_CBE_OE  <= next_s_cbe_oe;
      s_cnt     <= next_s_cnt;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);

  a_no_claim_other: assert property (addr_phase && !dec.claim0 && !dec.claim1
    |=> P_DEVSEL_N && pstate == PT_IDLE) else $error("unclaimed cycle got DEVSEL");
  a_type0_at_once: assert property (addr_phase && dec.claim0
    |=> !P_DEVSEL_N && P_STOP_N ##1 !P_TRDY_N) else $error("own access not immediate");
  a_burst_disc: assert property (!P_TRDY_N && !P_FRAME_N
    |-> !P_STOP_N) else $error("no disconnect on burst");
  a_read_dword: assert property (pstate == PT_DATA && !cur_dly && !cur_wr && !P_TRDY_N
    |-> P_AD_OE && P_AD_OUT == cfg_mem[cur_idx]) else $error("own read data wrong");
  a_first_retry: assert property (addr_phase && dec.claim1 && !dly_valid
    |=> !P_STOP_N && P_TRDY_N && !P_DEVSEL_N) else $error("first attempt not retried");
  a_sec_addr_fmt: assert property (sstate == ST_ADDR && !xl.special
    |-> S_AD_OUT[1:0] == 2'h0 && S_AD_OUT[15:11] == 5'h00
        && S_AD_OUT[10:2] == dly.addr[10:2]) else $error("bad secondary address");
  a_idsel_hot: assert property (sstate == ST_ADDR && dly.addr[15] == 1'b0
    |-> S_AD_OUT[31:16] == (16'h0001 << dly.addr[14:11])) else $error("IDSEL not one-hot");
  a_idsel_none: assert property (sstate == ST_ADDR && dly.addr[15] && !xl.special
    |-> S_AD_OUT[31:16] == 16'h0000) else $error("upper IDSEL bits set");
  a_single_data: assert property (sstate == ST_ADDR && !S_FRAME_N
    |=> S_FRAME_N && !S_IRDY_N) else $error("more than one data phase");
  a_sec_cmd: assert property (sstate == ST_ADDR && !xl.special
    |-> S_CBE_N == dly.cmd ##1 S_CBE_N == dly.be_n) else $error("command or enables changed");
  a_master_abort: assert property ((sstate == ST_DATA && S_DEVSEL_N && S_STOP_N)[*5]
    |=> sstate == ST_TURN && dly_done) else $error("master abort late");

  c_own_read: cover property (pstate == PT_DATA && !cur_dly && !cur_wr && xfer);
  c_own_disc: cover property (pstate == PT_HOLD && !P_STOP_N);
  c_dly_done: cover property (pstate == PT_DATA && cur_dly && xfer);
  c_sec_abort: cover property (sstate == ST_DATA && S_DEVSEL_N && s_cnt == 3'h4);

endmodule : pcb_cfg_bridge

// [logic/pcb_cfg.svh]
// Constants for the configuration decode and translate block
`ifndef PCB_CFG_SVH
`define PCB_CFG_SVH

// ----------------------------------------------------------------------
// Address formats and commands
// ----------------------------------------------------------------------
`define PCB_TYPE0        2'h0
`define PCB_TYPE1        2'h1
`define PCB_CMD_CFG_RD   4'hA
`define PCB_CMD_CFG_WR   4'hB
`define PCB_CMD_SPECIAL  4'h1
`define PCB_DEV_SPECIAL  5'h1F
`define PCB_REG_SPECIAL  6'h00
`define PCB_BUS_LSB      16
`define PCB_IDSEL_WIDTH  16

// ----------------------------------------------------------------------
// Own configuration space
// ----------------------------------------------------------------------
`define PCB_SECBUS_DW    6'h06
`define PCB_SECBUS_LSB   8
`define PCB_CFG_RST      32'h0000_0000
`define PCB_ALL_ONES     32'hFFFF_FFFF

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PCB_MABORT_CYC   3'h5

`endif

// [logic/pcb_pkg.sv]
// Types shared by the configuration decode and translate block
package pcb_pkg;

  typedef enum logic [2:0] {
    PT_IDLE, PT_DATA, PT_HOLD, PT_RETRY, PT_TABORT, PT_TURN
  } pcb_pstate_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_REQ, ST_ADDR, ST_DATA, ST_TURN
  } pcb_sstate_t;

  typedef struct packed {
    logic       type0;
    logic       type1;
    logic       claim0;
    logic       claim1;
    logic [5:0] reg_idx;
    logic       is_write;
  } pcb_dec_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [3:0]  cmd;
    logic [3:0]  be_n;
    logic [31:0] wdata;
  } pcb_req_t;

  typedef struct packed {
    logic [31:0] addr;
    logic        special;
  } pcb_xl_t;

endpackage : pcb_pkg

// [logic/pcb_cfg_decode.sv]
// Address-phase classifier for primary configuration transactions
`timescale 1ns/1ps
`include "pcb_cfg.svh"

module pcb_cfg_decode
  import pcb_pkg::*;
(
  // Address phase
  input  wire logic [31:0] ad,
  input  wire logic [3:0]  cbe_n,
  input  wire logic        idsel,
  // Own configuration
  input  wire logic [7:0]  sec_bus,
  // Result
  output pcb_dec_t         dec
);

  function automatic logic is_cfg(input logic [3:0] cmd);
    return (cmd == `PCB_CMD_CFG_RD) || (cmd == `PCB_CMD_CFG_WR);
  endfunction : is_cfg

  always_comb begin
    dec          = '0;
    dec.type0    = is_cfg(cbe_n) && (ad[1:0] == `PCB_TYPE0);
    dec.type1    = is_cfg(cbe_n) && (ad[1:0] == `PCB_TYPE1);
    dec.claim0   = dec.type0 && idsel;
    dec.claim1   = dec.type1 && (ad[`PCB_BUS_LSB +: 8] == sec_bus);
    // Function field 10:8 deliberately not looked at
    dec.reg_idx  = ad[7:2];
    dec.is_write = (cbe_n == `PCB_CMD_CFG_WR);
  end

endmodule : pcb_cfg_decode

// [logic/pcb_idsel_xlate.sv]
// Type 1 to Type 0 address translation with one-hot IDSEL lines
`timescale 1ns/1ps
`include "pcb_cfg.svh"

module pcb_idsel_xlate
  import pcb_pkg::*;
(
  // Captured Type 1 request
  input  wire logic [31:0] t1_addr,
  input  wire logic        is_write,
  // Translated secondary address
  output pcb_xl_t          xl
);

  logic [4:0]                   dev;
  logic [`PCB_IDSEL_WIDTH-1:0]  idsel;

  assign dev = t1_addr[15:11];

  // Numbers 10h and up leave every line low; 1Fh included
  genvar g;
  generate
    for (g = 0; g < `PCB_IDSEL_WIDTH; g++) begin : g_idsel
      assign idsel[g] = (dev == 5'(g));
    end
  endgenerate

  always_comb begin
    // Function and register fields kept, device field zeroed
    xl.addr    = {idsel, 5'h00, t1_addr[10:2], `PCB_TYPE0};
    xl.special = is_write && (dev == `PCB_DEV_SPECIAL)
                 && (t1_addr[7:2] == `PCB_REG_SPECIAL);
  end

endmodule : pcb_idsel_xlate

// [dv/pcb_sec_model.sv]
// Behavioural secondary-bus target that answers translated configuration cycles
`timescale 1ns/1ps
module pcb_sec_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        frame_n,
  input  wire logic        irdy_n,
  input  wire logic [31:0] ad,
  input  wire logic [3:0]  cbe_n,
  input  wire logic [1:0]  mode,
  output logic             devsel_n = 1,
  output logic             trdy_n = 1,
  output logic             stop_n = 1,
  output logic [31:0]      ad_o = 0
);
  logic [31:0] addr = 0;
  logic [2:0]  st = 0;
  logic [1:0]  wt = 0;
  logic        rd = 0;
  logic        rt = 0;
  // Mode 0 prompt, 1 three wait states, 2 target abort, 3 retry once
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {devsel_n, trdy_n, stop_n} <= 3'h7;
      st <= 0;
      rt <= 0;
      ad_o <= 0;
    end else begin
      // Released bus toggles so a stale value is never mistaken for data
      ad_o <= ~ad_o;
      case (st)
        0: if (!frame_n && |ad[31:16] && cbe_n[3:1] == 3'h5) begin
          addr <= ad;
          rd <= cbe_n == 4'hA;
          wt <= (mode == 1) ? 2'h3 : 2'h0;
          devsel_n <= 0;
          st <= (mode == 2) ? 3'h3 : (mode == 3 && !rt) ? 3'h5 : 3'h1;
          rt <= (mode == 3) && !rt;
        end
        1: if (wt != 0) wt <= wt - 1;
           else if (!irdy_n) begin
             trdy_n <= 0;
             st <= 2;
             if (rd) ad_o <= ~addr;
           end
        2: begin {devsel_n, trdy_n} <= 2'h3; st <= 0; end
        3: begin devsel_n <= 1; stop_n <= 0; st <= 4; end
        5: begin stop_n <= 0; st <= 4; end
        default: begin {devsel_n, stop_n} <= 2'h3; st <= 0; end
      endcase
    end
  end
endmodule : pcb_sec_model

// [dv/testbench.sv]
// Self-checking bench for the configuration decode and translate block
`timescale 1ns/1ps
module testbench;
  import pcb_pkg::*;
  logic        MCLK = 0, NRST = 0, P_FRAME_N = 1, P_IRDY_N = 1, P_IDSEL = 0, S_GNT_N = 1, sp;
  logic [31:0] p_drv = 0, sa = 0, sw = 0, rsp, rd, es;
  logic [3:0]  P_CBE_N = 4'hF, sc = 0, sbe = 0;
  logic [1:0]  mode = 0;
  logic [31:0] ra [8];
  logic [3:0]  rc [8];
  wire  [31:0] P_AD_IN, P_AD_OUT, S_AD_IN, S_AD_OUT, sec_o;
  wire  [3:0]  S_CBE_N;
  wire         P_AD_OE, P_DEVSEL_N, P_TRDY_N, P_STOP_N, P_CTL_OE, S_DEVSEL_N, S_TRDY_N;
  wire         S_STOP_N, S_REQ_N, S_FRAME_N, S_IRDY_N, S_CTL_OE, S_AD_OE, S_CBE_OE;
  int          bad_count = 0, n_compared = 0, cyc = 0;

  // ------------------------------------------------------------
  // Wires, design and far side
  // ------------------------------------------------------------
  assign P_AD_IN = P_AD_OE ? P_AD_OUT : p_drv;
  assign S_AD_IN = S_AD_OE ? S_AD_OUT : sec_o;
  pcb_cfg_bridge i_dut (.MCLK, .NRST, .P_FRAME_N, .P_IRDY_N, .P_IDSEL, .P_AD_IN, .P_CBE_N,
    .P_AD_OUT, .P_AD_OE, .P_DEVSEL_N, .P_TRDY_N, .P_STOP_N, .P_CTL_OE, .S_GNT_N, .S_AD_IN,
    .S_DEVSEL_N, .S_TRDY_N, .S_STOP_N, .S_REQ_N, .S_FRAME_N, .S_IRDY_N, .S_CTL_OE,
    .S_AD_OUT, .S_AD_OE, .S_CBE_N, .S_CBE_OE);
  pcb_sec_model i_sec (.clk(MCLK), .rst_n(NRST), .frame_n(S_FRAME_N), .irdy_n(S_IRDY_N),
    .ad(S_AD_IN), .cbe_n(S_CBE_N), .mode(mode), .devsel_n(S_DEVSEL_N), .trdy_n(S_TRDY_N),
    .stop_n(S_STOP_N), .ad_o(sec_o));

  initial forever #5 MCLK = ~MCLK;
  always @(negedge MCLK) S_GNT_N <= S_REQ_N;
  always @(posedge MCLK) begin
    if (S_FRAME_N === 1'b0 && S_CTL_OE === 1'b1) begin sa <= S_AD_OUT; sc <= S_CBE_N; end
    if ({S_IRDY_N, S_DEVSEL_N, S_TRDY_N} === 3'b000) begin sw <= S_AD_OUT; sbe <= S_CBE_N; end
  end
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 20000) begin bad_count++; summarize(); end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Response: 0 done, 1 done with disconnect, 2 retry, 3 target abort, 4 none
  task automatic xfer(input logic [31:0] a, input logic [31:0] d, input logic [3:0] c,
                      input logic [3:0] be, input logic sel, input logic brst,
                      output logic [31:0] r, output logic [31:0] q);
    @(negedge MCLK);
    P_FRAME_N = 0; p_drv = a; P_CBE_N = c; P_IDSEL = sel;
    @(negedge MCLK);
    P_FRAME_N = !brst; P_IRDY_N = 0; P_CBE_N = be; p_drv = d; P_IDSEL = 0;
    r = 4;
    q = 0;
    for (int n = 0; n < 12 && r == 4; n++) begin
      @(posedge MCLK);
      if (P_TRDY_N === 1'b0) begin r = P_STOP_N ? 0 : 1; q = P_AD_IN; end
      else if (P_STOP_N === 1'b0) r = P_DEVSEL_N ? 3 : 2;
    end
    @(negedge MCLK);
    P_FRAME_N = 1; P_IRDY_N = 1; P_CBE_N = 4'hF; p_drv = ~p_drv;
    @(negedge MCLK);
  endtask : xfer

  task automatic t1(input logic [31:0] a, input logic [31:0] d, input logic [3:0] c,
                    input logic [3:0] be, output logic [31:0] r, output logic [31:0] q);
    xfer(a, d, c, be, 1'b0, 1'b0, r, q);
    chk(r, 2);
    for (int k = 0; k < 20 && r == 2; k++) begin
      repeat (12) @(posedge MCLK);
      xfer(a, d, c, be, 1'b0, 1'b0, r, q);
    end
  endtask : t1

  function automatic logic [31:0] t1a(input logic [4:0] dv, input logic [2:0] fn,
                                      input logic [5:0] rg);
    return {8'h00, 8'h03, dv, fn, rg, 2'b01};
  endfunction : t1a

  function automatic logic [31:0] xa(input logic [31:0] x);
    return {(x[15] ? 16'h0000 : 16'h0001 << x[14:11]), 5'h00, x[10:2], 2'b00};
  endfunction : xa

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    ra = '{t1a(0, 0, 1), t1a(5, 3, 6'h12), t1a(15, 7, 6'h3F), t1a(16, 0, 0),
           t1a(5'h1E, 2, 4), t1a(5'h1F, 0, 1), t1a(5'h1F, 7, 0), t1a(2, 1, 8)};
    rc = '{4'hA, 4'hA, 4'hB, 4'hA, 4'hB, 4'hA, 4'hB, 4'hB};
    repeat (4) @(posedge MCLK);
    chk(32'({P_DEVSEL_N, P_CTL_OE, S_REQ_N, S_CTL_OE, P_AD_OE, S_AD_OE, S_CBE_OE}), 32'h0000_0050);
    @(negedge MCLK) NRST = 1;
    repeat (2) @(posedge MCLK);
    xfer(32'h0000_0018, 32'h0000_0300, 4'hB, 4'h0, 1'b1, 1'b0, rsp, rd);
    chk(rsp, 0);
    xfer(32'h0000_0518, 32'h0000_0000, 4'hA, 4'hF, 1'b1, 1'b0, rsp, rd);
    chk(rd, 32'h0000_0300);
    xfer(32'h0000_0018, 32'h0000_0000, 4'hA, 4'h0, 1'b1, 1'b1, rsp, rd);
    chk(rsp, 1);
    xfer(32'h0000_0018, 32'h0000_0000, 4'hA, 4'h0, 1'b0, 1'b0, rsp, rd);
    chk(rsp, 4);
    xfer(32'h0000_0018, 32'h0000_0000, 4'h6, 4'h0, 1'b1, 1'b0, rsp, rd);
    chk(rsp, 4);
    xfer(32'h0004_0005, 32'h0000_0000, 4'hA, 4'h0, 1'b0, 1'b0, rsp, rd);
    chk(rsp, 4);
    $display("test own_space done");
    for (int i = 0; i < 8; i++) begin
      mode = (i == 7) ? 2'h3 : {1'b0, i[0]};
      sp = rc[i] == 4'hB && ra[i][15:11] == 5'h1F && ra[i][7:2] == 6'h00;
      es = sp ? ra[i] : xa(ra[i]);
      t1(ra[i], ~ra[i], rc[i], 4'(i), rsp, rd);
      chk(rsp, 0);
      chk(sa, es);
      chk(32'(sc), sp ? 32'h0000_0001 : 32'(rc[i]));
      if (rc[i] == 4'hA) chk(rd, |es[31:16] ? ~es : 32'hFFFF_FFFF);
      else if (!sp && |es[31:16]) chk({sw[27:0], sbe}, {~ra[i][27:0], 4'(i)});
    end
    $display("test translate done");
    mode = 2;
    t1(t1a(3, 0, 2), 32'h0000_0000, 4'hA, 4'h0, rsp, rd);
    chk(rsp, 3);
    $display("test target_abort done");
    summarize();
  end
endmodule : testbench
